// file: design/rsst_params.svh
// named offsets, codes and timing counts of the serial slave and time-stamp block
// assumes it is included by bare name by the package and the top module
`ifndef RSST_PARAMS_SVH
`define RSST_PARAMS_SVH

`define RSST_ADDR_USER0     8'h12
`define RSST_ADDR_USER1     8'h13
`define RSST_ADDR_TS_FIRST  8'h14
`define RSST_ADDR_TS_LAST   8'h19
`define RSST_PTR_RESET      8'h00
`define RSST_NO_DATA        8'h00
// neutral identifier of our own, arbitrary value
`define RSST_SLAVE_ID       7'h2a
`define RSST_LAST_BIT       3'h7
`define RSST_TS_COUNT       6
`define RSST_PWRUP_NS       2000
`define RSST_SYS_PERIOD_NS  20
`define RSST_PWRUP_CYC      ((`RSST_PWRUP_NS + `RSST_SYS_PERIOD_NS - 1) / `RSST_SYS_PERIOD_NS)

`endif

// file: design/rsst_pkg.sv
// types shared by the serial slave and time-stamp block
// assumes rsst_params.svh is on the include path
`include "rsst_params.svh"

package rsst_pkg;

    // calendar snapshot, weekday deliberately absent
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } rsst_cal_t;

    // one register access carried from the link domain to the system domain
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsst_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLAVE,
        ST_WORD,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_MACK
    } rsst_st_t;

endpackage

// file: design/rsst_top.sv
// two-wire serial slave port with user bytes and event time-stamp registers
// assumes: LINK_CLK free running, much faster than the serial clock; CAL_NOW, TAMPER_FLAG_CLR
// and TAMPER_IND_EN come from logic on CLK_SYS; SCL/SDA/TAMPER_INPUT are raw pins
// Notes on behaviour
// - two read/write user bytes sit just below the time-stamp group
// - rising tamper input copies calendar into six time-stamp registers
// - capture also sets the seen flag and toggles indicator when enabled
// - stamp holds seconds to year in calendar format, no weekday
// - only first event stamped; held until flag cleared and new event
// - no register access clears the stamps; only power loss does
// - device is slave only; master starts transfers and drives clock
// - bytes travel most significant bit first both ways
// - data changes with clock low; high-clock changes are start or stop
// - data line released after power-up; early starts ignored
// - both lines watched; nothing answered before a start
// - stop after read or write returns the port to standby
// - transmitter releases after eight bits; receiver pulls low on ninth
// - device acks address, word address, write data; master acks read data
// - first byte: seven-bit identifier then read-high write-low bit
// - identifier compared after whole byte; ack only on match
// - word address counter starts at zero; current read begins there
// - write is start, slave byte, word address, data, stop; all acked
// - read is dummy write of address, repeated start, slave byte read
// - device keeps sending while master acks; master stops after last
// - pointer loads from word address, increments, wraps after top to zero
`timescale 1ns/100ps
`include "rsst_params.svh"

module rsst_top #(
    parameter logic [6:0] SLAVE_ID  = `RSST_SLAVE_ID,
    parameter int         PWRUP_CYC = `RSST_PWRUP_CYC
) (
    input  wire logic               CLK_SYS,
    input  wire logic               RST_N,
    input  wire logic               LINK_CLK,
    input  wire logic               SCL_IN,
    input  wire logic               SDA_IN,
    output logic                    SDA_OUT,
    output logic                    SDA_OE,
    input  wire logic               TAMPER_INPUT,
    input  wire rsst_pkg::rsst_cal_t CAL_NOW,
    input  wire logic               TAMPER_FLAG_CLR,
    input  wire logic               TAMPER_IND_EN,
    output logic                    TAMPER_SEEN_FLAG,
    output logic                    TAMPER_INDICATOR_OUTPUT
);
    import rsst_pkg::*;

    localparam int PW = $clog2(PWRUP_CYC + 1);

    // ---------------- system domain ----------------
    logic [PW-1:0] pwr_cnt_ff;
    logic          pwr_ready_ff;
    logic          evt_s1_ff, evt_s2_ff, evt_s3_ff;
    logic          flag_ff, ind_ff;
    logic [7:0]    ts_ff [`RSST_TS_COUNT];
    logic [7:0]    user_ff [2];
    logic          req_s1_ff, req_s2_ff, req_s3_ff;
    logic          ack_tgl_ff;
    logic [7:0]    sys_rdata_ff;

    // link-domain registers read across the crossing
    rsst_req_t     req_ff;
    logic          req_tgl_ff;

    wire evt_rise   = evt_s2_ff & ~evt_s3_ff;
    wire flag_eff   = flag_ff & ~TAMPER_FLAG_CLR;
    wire capture    = evt_rise & ~flag_eff;
    wire nxt_flag   = capture | flag_eff;
    wire nxt_ind    = ind_ff ^ (capture & TAMPER_IND_EN);
    wire req_new    = req_s2_ff ^ req_s3_ff;
    wire [7:0] ts_off = req_ff.addr - `RSST_ADDR_TS_FIRST;
    wire ts_hit     = (req_ff.addr >= `RSST_ADDR_TS_FIRST) && (req_ff.addr <= `RSST_ADDR_TS_LAST);
    wire u0_hit     = req_ff.addr == `RSST_ADDR_USER0;
    wire u1_hit     = req_ff.addr == `RSST_ADDR_USER1;
    wire wr_u0      = req_new & req_ff.we & u0_hit;
    wire wr_u1      = req_new & req_ff.we & u1_hit;
    wire [7:0] rd_mux = u0_hit ? user_ff[0] :
                        u1_hit ? user_ff[1] :
                        ts_hit ? ts_ff[ts_off[2:0]] : `RSST_NO_DATA;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pwr_cnt_ff   <= '0;
            pwr_ready_ff <= 1'b0;
        end else if (!pwr_ready_ff) begin
            pwr_cnt_ff   <= pwr_cnt_ff + PW'(1);
            pwr_ready_ff <= pwr_cnt_ff == PW'(PWRUP_CYC - 1);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            evt_s1_ff <= 1'b0;
            evt_s2_ff <= 1'b0;
            evt_s3_ff <= 1'b0;
            flag_ff   <= 1'b0;
            ind_ff    <= 1'b0;
        end else begin
            evt_s1_ff <= TAMPER_INPUT;
            evt_s2_ff <= evt_s1_ff;
            evt_s3_ff <= evt_s2_ff;
            flag_ff   <= nxt_flag;
            ind_ff    <= nxt_ind;
        end
    end

    // stamps and user bytes have no reset: only a power loss may erase them
    always_ff @(posedge CLK_SYS) begin
        if (capture) begin
            ts_ff[0] <= CAL_NOW.seconds;
            ts_ff[1] <= CAL_NOW.minutes;
            ts_ff[2] <= CAL_NOW.hours;
            ts_ff[3] <= CAL_NOW.date;
            ts_ff[4] <= CAL_NOW.month;
            ts_ff[5] <= CAL_NOW.year;
        end
        if (wr_u0) begin
            user_ff[0] <= req_ff.wdata;
        end
        if (wr_u1) begin
            user_ff[1] <= req_ff.wdata;
        end
    end

    // payload in req_ff is held stable by the link side until the answer toggles back
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            req_s1_ff    <= 1'b0;
            req_s2_ff    <= 1'b0;
            req_s3_ff    <= 1'b0;
            ack_tgl_ff   <= 1'b0;
            sys_rdata_ff <= `RSST_NO_DATA;
        end else begin
            req_s1_ff  <= req_tgl_ff;
            req_s2_ff  <= req_s1_ff;
            req_s3_ff  <= req_s2_ff;
            ack_tgl_ff <= ack_tgl_ff ^ req_new;
            if (req_new) begin
                sys_rdata_ff <= rd_mux;
            end
        end
    end

    assign TAMPER_SEEN_FLAG        = flag_ff;
    assign TAMPER_INDICATOR_OUTPUT = ind_ff;

    capture_sets_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        capture |=> flag_ff && (ts_ff[0] == $past(CAL_NOW.seconds)))
        else $error("capture did not set flag or load seconds");

    stamp_held_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        flag_ff && !TAMPER_FLAG_CLR |=> $stable(ts_ff[5]) && $stable(ts_ff[0]) && flag_ff)
        else $error("stamp changed while flag set");

    indicator_toggle_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        evt_rise && !flag_ff && TAMPER_IND_EN |=> ind_ff != $past(ind_ff))
        else $error("indicator did not change on capture");

    stamp_write_ignored_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        req_new && req_ff.we && ts_hit && !capture |=> $stable(ts_ff[ts_off[2:0]]))
        else $error("stamp register changed by write");

    // ---------------- link domain ----------------
    logic       lrst_s1_ff, lrst_n_ff;
    logic       scl_s1_ff, scl_s2_ff, scl_s3_ff;
    logic       sda_s1_ff, sda_s2_ff, sda_s3_ff;
    logic       rdy_s1_ff, rdy_s2_ff;
    logic       ack_s1_ff, ack_s2_ff, ack_s3_ff;
    logic [7:0] link_rdata_ff;
    rsst_st_t   st_ff, after_ff, nxt_st, nxt_after;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [7:0] rx_ff, nxt_rx, tx_ff, nxt_tx, ptr_ff, nxt_ptr;
    logic       oe_ff, nxt_oe, done_ff, nxt_done, mack_ff, nxt_mack;
    logic       sda_out_ff, nxt_tgl;
    rsst_req_t  nxt_req;

    wire scl_rise = scl_s2_ff & ~scl_s3_ff;
    wire scl_fall = ~scl_s2_ff & scl_s3_ff;
    wire scl_high = scl_s2_ff & scl_s3_ff;
    wire start    = scl_high & ~sda_s2_ff & sda_s3_ff;
    wire stop     = scl_high & sda_s2_ff & ~sda_s3_ff;
    wire ack_new  = ack_s2_ff ^ ack_s3_ff;
    wire id_match = rx_ff[7:1] == SLAVE_ID;
    wire rd_sel   = rx_ff[0];
    wire [7:0] ptr_inc = (ptr_ff == `RSST_ADDR_TS_LAST) ? `RSST_PTR_RESET : ptr_ff + 8'h01;

    // reset asserts at once, releases on the link clock
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lrst_s1_ff <= 1'b0;
            lrst_n_ff  <= 1'b0;
        end else begin
            lrst_s1_ff <= 1'b1;
            lrst_n_ff  <= lrst_s1_ff;
        end
    end

    always_ff @(posedge LINK_CLK or negedge lrst_n_ff) begin
        if (!lrst_n_ff) begin
            {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
            {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
            {rdy_s1_ff, rdy_s2_ff}            <= 2'h0;
            {ack_s1_ff, ack_s2_ff, ack_s3_ff} <= 3'h0;
            link_rdata_ff                     <= `RSST_NO_DATA;
        end else begin
            {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {SCL_IN, scl_s1_ff, scl_s2_ff};
            {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {SDA_IN, sda_s1_ff, sda_s2_ff};
            {rdy_s1_ff, rdy_s2_ff}            <= {pwr_ready_ff, rdy_s1_ff};
            {ack_s1_ff, ack_s2_ff, ack_s3_ff} <= {ack_tgl_ff, ack_s1_ff, ack_s2_ff};
            if (ack_new) begin
                link_rdata_ff <= sys_rdata_ff;
            end
        end
    end

    always_comb begin
        nxt_st    = st_ff;
        nxt_after = after_ff;
        nxt_cnt   = cnt_ff;
        nxt_rx    = rx_ff;
        nxt_tx    = tx_ff;
        nxt_ptr   = ptr_ff;
        nxt_oe    = oe_ff;
        nxt_done  = done_ff;
        nxt_mack  = mack_ff;
        nxt_req   = req_ff;
        nxt_tgl   = req_tgl_ff;
        if (start && rdy_s2_ff) begin
            nxt_st   = ST_SLAVE;
            nxt_cnt  = '0;
            nxt_done = 1'b0;
            nxt_oe   = 1'b0;
        end else if (stop) begin
            nxt_st = ST_IDLE;
            nxt_oe = 1'b0;
        end else begin
            unique case (st_ff)
                ST_IDLE: begin
                    nxt_oe = 1'b0;
                end
                ST_SLAVE, ST_WORD, ST_WDATA: begin
                    if (scl_rise && !done_ff) begin
                        nxt_rx   = {rx_ff[6:0], sda_s2_ff};
                        nxt_cnt  = cnt_ff + 3'h1;
                        nxt_done = cnt_ff == `RSST_LAST_BIT;
                    end else if (scl_fall && done_ff) begin
                        nxt_done = 1'b0;
                        nxt_cnt  = '0;
                        nxt_st   = ST_ACK;
                        nxt_oe   = 1'b1;
                        if (st_ff == ST_SLAVE) begin
                            if (!id_match) begin
                                nxt_st = ST_IDLE;
                                nxt_oe = 1'b0;
                            end else if (rd_sel) begin
                                nxt_after = ST_RDATA;
                                nxt_req   = '{we: 1'b0, addr: ptr_ff, wdata: `RSST_NO_DATA};
                                nxt_tgl   = ~req_tgl_ff;
                            end else begin
                                nxt_after = ST_WORD;
                            end
                        end else if (st_ff == ST_WORD) begin
                            nxt_after = ST_WDATA;
                            nxt_ptr   = rx_ff;
                        end else begin
                            nxt_after = ST_IDLE;
                            nxt_req   = '{we: 1'b1, addr: ptr_ff, wdata: rx_ff};
                            nxt_tgl   = ~req_tgl_ff;
                            nxt_ptr   = ptr_inc;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        nxt_oe = 1'b0;
                        nxt_st = after_ff;
                        if (after_ff == ST_RDATA) begin
                            nxt_tx  = link_rdata_ff;
                            nxt_oe  = ~link_rdata_ff[7];
                            nxt_cnt = '0;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_ff == `RSST_LAST_BIT) begin
                            nxt_oe  = 1'b0;
                            nxt_st  = ST_MACK;
                            nxt_ptr = ptr_inc;
                            nxt_req = '{we: 1'b0, addr: ptr_inc, wdata: `RSST_NO_DATA};
                            nxt_tgl = ~req_tgl_ff;
                        end else begin
                            nxt_tx  = {tx_ff[6:0], 1'b0};
                            nxt_oe  = ~tx_ff[6];
                            nxt_cnt = cnt_ff + 3'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nxt_mack = ~sda_s2_ff;
                    end else if (scl_fall) begin
                        if (mack_ff) begin
                            nxt_st  = ST_RDATA;
                            nxt_tx  = link_rdata_ff;
                            nxt_oe  = ~link_rdata_ff[7];
                            nxt_cnt = '0;
                        end else begin
                            nxt_st = ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // the device never drives the serial clock; only its data line, and only low
    always_ff @(posedge LINK_CLK or negedge lrst_n_ff) begin
        if (!lrst_n_ff) begin
            st_ff      <= ST_IDLE;
            after_ff   <= ST_IDLE;
            cnt_ff     <= '0;
            rx_ff      <= '0;
            tx_ff      <= '0;
            ptr_ff     <= `RSST_PTR_RESET;
            oe_ff      <= 1'b0;
            done_ff    <= 1'b0;
            mack_ff    <= 1'b0;
            req_ff     <= '0;
            req_tgl_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            after_ff   <= nxt_after;
            cnt_ff     <= nxt_cnt;
            rx_ff      <= nxt_rx;
            tx_ff      <= nxt_tx;
            ptr_ff     <= nxt_ptr;
            oe_ff      <= nxt_oe;
            done_ff    <= nxt_done;
            mack_ff    <= nxt_mack;
            req_ff     <= nxt_req;
            req_tgl_ff <= nxt_tgl;
            sda_out_ff <= 1'b0;
        end
    end

    assign SDA_OE  = oe_ff;
    assign SDA_OUT = sda_out_ff;

    early_start_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        start && !rdy_s2_ff && st_ff == ST_IDLE |=> st_ff == ST_IDLE && !oe_ff)
        else $error("start accepted during power-up");

    stop_standby_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        stop && !start |=> st_ff == ST_IDLE ##1 !oe_ff)
        else $error("stop did not return to standby");

    addr_ack_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        st_ff == ST_SLAVE && scl_fall && done_ff && id_match && !stop && !start
        |=> oe_ff && st_ff == ST_ACK)
        else $error("matching slave byte not acknowledged");

    no_match_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        st_ff == ST_SLAVE && scl_fall && done_ff && !id_match && !start
        |=> !oe_ff && st_ff == ST_IDLE)
        else $error("mismatched slave byte acknowledged");

    ptr_wrap_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        st_ff == ST_RDATA && scl_fall && cnt_ff == `RSST_LAST_BIT && !start && !stop
        |=> ptr_ff == (($past(ptr_ff) == `RSST_ADDR_TS_LAST) ? `RSST_PTR_RESET
                                                              : $past(ptr_ff) + 8'h01))
        else $error("read pointer did not step or wrap");

    msb_first_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        st_ff == ST_RDATA && scl_fall && cnt_ff != `RSST_LAST_BIT && !start && !stop
        |=> oe_ff == ~$past(tx_ff[6]))
        else $error("read bits not sent msb first");

    ack_release_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        st_ff == ST_ACK && scl_fall && after_ff != ST_RDATA && !start && !stop |=> !oe_ff)
        else $error("data line held after acknowledge");

endmodule // rsst_top

// file: testbench/rsst_master.sv
// behavioural two-wire bus master at the far side of the serial slave port
// assumes the bench resolves the open-drain data wire and returns it on sda
`timescale 1ns/100ps

module rsst_master #(
    parameter int Q_NS = 800
) (
    output logic     scl,
    output logic     sda_pull,
    input  wire logic sda
);
    // quarter bit of 800 ns keeps each clock phase above the port's sync need
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // start or repeated start; data released with the clock low, then pulled low while the clock is high
    task automatic start_cond();
        #(Q_NS) sda_pull = 1'b0;
        #(Q_NS) scl = 1'b1;
        #(Q_NS) sda_pull = 1'b1;
        #(Q_NS) scl = 1'b0;
    endtask

    task automatic stop_cond();
        #(Q_NS) sda_pull = 1'b1;
        #(Q_NS) scl = 1'b1;
        #(Q_NS) sda_pull = 1'b0;
        #(Q_NS);
    endtask

    // a one releases the wire, so the same slot also reads the other party
    task automatic bit_slot(input logic b, output logic v);
        #(Q_NS) sda_pull = !b;
        #(Q_NS) scl = 1'b1;
        #(Q_NS) v = sda;
        #(Q_NS) scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], x);
        end
        bit_slot(1'b1, ack);
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, d[i]);
        end
        bit_slot(nack, x);
    endtask
endmodule // rsst_master

// file: testbench/rsst_top_bench.sv
// self-checking bench: serial register accesses and tamper events
// assumes rsst_params.svh on the include path and the master model beside it
`timescale 1ns/100ps
`include "rsst_params.svh"

module rsst_top_bench;
    import rsst_pkg::*;
    localparam logic [6:0]  ID = `RSST_SLAVE_ID;
    localparam logic [47:0] C1 = 48'h24_12_31_23_59_58;
    localparam logic [47:0] C2 = 48'h25_01_02_03_04_05;
    logic       clk_sys, rst_n, link_clk, tamper_input, flag_clr, ind_en;
    rsst_cal_t  cal_now;
    logic       sda_out, sda_oe, seen_flag, ind_out, scl, m_pull, ack;
    wire        sda_w;
    logic [7:0] got [0:31];
    int         n_fail, check_count;

    // pull-up on the data wire; either party may pull it low
    assign sda_w = !(m_pull || (sda_oe && !sda_out));

    // power-up window of 4 us, long enough for a start issued right after reset to land in it
    rsst_top #(.PWRUP_CYC(200)) u_rsst_top (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .LINK_CLK(link_clk), .SCL_IN(scl),
        .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .TAMPER_INPUT(tamper_input), .CAL_NOW(cal_now), .TAMPER_FLAG_CLR(flag_clr),
        .TAMPER_IND_EN(ind_en), .TAMPER_SEEN_FLAG(seen_flag),
        .TAMPER_INDICATOR_OUTPUT(ind_out));

    rsst_master u_rsst_master (.scl(scl), .sda_pull(m_pull), .sda(sda_w));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic send(input logic [7:0] b);
        u_rsst_master.send_byte(b, ack);
        check("ack", 8'h00, {7'h00, ack});
    endtask

    task automatic read_n(input int n);
        u_rsst_master.start_cond();
        send({ID, 1'b1});
        for (int i = 0; i < n; i++) begin
            u_rsst_master.recv_byte(i == n - 1, got[i]);
        end
        u_rsst_master.stop_cond();
    endtask

    task automatic addr_phase(input logic [7:0] a);
        u_rsst_master.start_cond();
        send({ID, 1'b0});
        send(a);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        addr_phase(a);
        send(d);
        u_rsst_master.stop_cond();
    endtask

    task automatic tamper(input logic [47:0] cal, input logic exp_ind);
        @(posedge clk_sys) #2 cal_now = cal;
        tamper_input = 1'b1;
        repeat (6) @(posedge clk_sys);
        check("seen flag", 8'h01, {7'h00, seen_flag});
        check("indicator", {7'h00, exp_ind}, {7'h00, ind_out});
        #2 tamper_input = 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic clear_flag();
        @(posedge clk_sys) #2 flag_clr = 1'b1;
        @(posedge clk_sys) #2 flag_clr = 1'b0;
        repeat (2) @(posedge clk_sys);
        check("seen flag", 8'h00, {7'h00, seen_flag});
    endtask

    // hang guard: a limit that runs out counts against the run
    initial begin
        repeat (95000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        rst_n = 1'b0;
        tamper_input = 1'b0;
        flag_clr = 1'b0;
        ind_en = 1'b1;
        cal_now = C1;
        // longer than three cycles so the slower link clock also sees reset
        repeat (7) @(posedge clk_sys);
        #2 rst_n = 1'b1;
        @(posedge clk_sys) #2;
        check("data enable", 8'h00, {7'h00, sda_oe});
        check("data value", 8'h00, {7'h00, sda_out});
        check("indicator", 8'h00, {7'h00, ind_out});
        // start lands inside the power-up window, so the slave byte goes unanswered
        u_rsst_master.start_cond();
        u_rsst_master.send_byte({ID, 1'b1}, ack);
        check("early start ack", 8'h01, {7'h00, ack});
        u_rsst_master.stop_cond();
        repeat (150) @(posedge clk_sys);
        read_n(1);
        check("current read", 8'h00, got[0]);
        u_rsst_master.start_cond();
        u_rsst_master.send_byte({ID ^ 7'h01, 1'b0}, ack);
        check("foreign id ack", 8'h01, {7'h00, ack});
        u_rsst_master.stop_cond();
        reg_write(8'h12, 8'ha5);
        reg_write(8'h13, 8'h3c);
        tamper(C1, 1'b1);
        tamper(C2, 1'b1);
        addr_phase(8'h12);
        // runs past the top, wraps, and comes round to the first user byte again
        read_n(27);
        check("user byte 0", 8'ha5, got[0]);
        check("user byte 1", 8'h3c, got[1]);
        for (int i = 0; i < 6; i++) begin
            check("stamp", C1[8*i +: 8], got[i+2]);
        end
        check("wrapped byte", 8'h00, got[8]);
        check("wrapped byte", 8'h00, got[9]);
        check("after wrap", 8'ha5, got[26]);
        reg_write(8'h14, 8'h77);
        addr_phase(8'h14);
        read_n(1);
        check("stamp seconds", C1[7:0], got[0]);
        clear_flag();
        tamper(C2, 1'b0);
        addr_phase(8'h14);
        read_n(6);
        for (int i = 0; i < 6; i++) begin
            check("restamp", C2[8*i +: 8], got[i]);
        end
        clear_flag();
        #2 ind_en = 1'b0;
        tamper(C1, 1'b0);
        tally_and_finish();
    end
endmodule // rsst_top_bench
